// >>> design/oca_slave.sv
// What this block does
// - echo each properly addressed frame back unless answering cannot_comply
// - act only after three identical frames
// - count identical receptions per pair only
// - reply in the next returning frame
// - loopback and crc commands latch together
// - unlatch-all clears every latched condition
// - slave never sends a message unprompted
// - unaddressed network end sends keep-latched idle
// - regenerator passes upstream frames unless itself addressed
// - addressed regenerator overwrites upstream frames
// - pair commands echo and act per pair
// - global command judged on selected pair
// - answers go only on pairs that carried a frame
// - unsupported third repeat answers cannot_comply
// - invalid-in-state command enters cannot_comply
// - cannot_comply code two bits from others
// - three unlatch-all leave cannot_comply
// - frame is 13 bits per line frame
// - addresses 11, 00, 10; reply own address
`timescale 1ns/100ps
`default_nettype none
module oca_slave
   import oca_pkg::*;
#(
   parameter int unsigned NUM_PAIRS = 3,  // pairs carrying the channel
   parameter bit IS_REGEN = 1'b0          // one: regenerator, zero: network end
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   // frames from the master direction, one strobe per line frame
   input wire logic [NUM_PAIRS-1:0] i_dn_valid,
   input wire logic [NUM_PAIRS-1:0][12:0] i_dn_frame,
   // frames from the network end toward the master (regenerator only)
   input wire logic [NUM_PAIRS-1:0] i_up_valid,
   input wire logic [NUM_PAIRS-1:0][12:0] i_up_frame,
   // pair on which global commands are judged
   input wire logic [1:0] i_sel_pair,
   // frames toward the master
   output logic [NUM_PAIRS-1:0] o_up_valid,
   output logic [NUM_PAIRS-1:0][12:0] o_up_frame,
   // frames passed on toward the network end (regenerator only)
   output logic [NUM_PAIRS-1:0] o_dn_valid,
   output logic [NUM_PAIRS-1:0][12:0] o_dn_frame,
   // latched conditions per pair
   output logic [NUM_PAIRS-1:0] o_loopback,
   output logic [NUM_PAIRS-1:0] o_crc_request,
   output logic [NUM_PAIRS-1:0] o_crc_notify,
   output logic [NUM_PAIRS-1:0] o_cannot_comply,
   // one-cycle pulse when a command takes effect
   output logic o_action,
   output logic [7:0] o_action_code
);
   // ************************************************************
   // own address and fixed replies
   // ************************************************************
   localparam logic [1:0] MY_ADDR = IS_REGEN ? ADDR_REGEN : ADDR_NET_END;

   // keep-latched idle with own address, sent when not addressed
   localparam logic [12:0] IDLE_FRAME = {MY_ADDR, 1'b1, 1'b0, 1'b1, OP_KEEP_LATCHED};

   // cannot_comply reply, own address
   localparam logic [12:0] CC_FRAME = {MY_ADDR, 1'b1, 1'b0, 1'b1, OP_CANNOT_COMPLY};

   // ************************************************************
   // state of the block
   // ************************************************************
   typedef struct packed {
      logic [NUM_PAIRS-1:0] up_v;           // frame toward master
      logic [NUM_PAIRS-1:0][12:0] up_f;
      logic [NUM_PAIRS-1:0] dn_v;           // forwarded frame downstream
      logic [NUM_PAIRS-1:0][12:0] dn_f;
      logic [NUM_PAIRS-1:0][12:0] resp;     // last reply per pair
      logic [NUM_PAIRS-1:0] ovr;            // regenerator overwriting
      logic [NUM_PAIRS-1:0] loop;           // latched loopback
      logic [NUM_PAIRS-1:0] crc_req;        // latched crc request
      logic [NUM_PAIRS-1:0] crc_ntf;        // latched crc notify
      logic [NUM_PAIRS-1:0] cc;             // cannot_comply state
      logic act_v;                          // action pulse
      logic [7:0] act_code;
   } oca_st_t;

   oca_st_t s_q;
   oca_st_t s_d;

   // run counters, one per pair
   logic [NUM_PAIRS-1:0][1:0] run;
   logic [NUM_PAIRS-1:0] third;

   // ************************************************************
   // per-pair identity counters
   // ************************************************************
   // each pair counts on its own, runs are never merged across pairs
   generate
      for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
         oca_run_count u_run (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_valid(i_dn_valid[g]),
            .i_frame(i_dn_frame[g]),
            .o_run(run[g]),
            .o_third(third[g])
         );
      end
   endgenerate

   // ************************************************************
   // command evaluation and reply
   // ************************************************************
   // set and clear masks are collected over all pairs first, so a
   // latch set on one pair survives a clear arriving on another
   always_comb begin
      logic [12:0] fr;
      logic [12:0] rsp;
      logic [7:0] op;
      logic hit;
      logic known;
      logic bad;
      logic sel_ok;
      logic [NUM_PAIRS-1:0] clr;
      logic [NUM_PAIRS-1:0] set_loop;
      logic [NUM_PAIRS-1:0] set_crq;
      logic [NUM_PAIRS-1:0] set_cnt;
      logic [NUM_PAIRS-1:0] set_cc;
      fr = FRAME_RST;
      rsp = FRAME_RST;
      op = 8'h00;
      hit = 1'b0;
      known = 1'b0;
      bad = 1'b0;
      sel_ok = 1'b0;
      clr = '0;
      set_loop = '0;
      set_crq = '0;
      set_cnt = '0;
      set_cc = '0;
      s_d = s_q;
      s_d.up_v = '0;
      s_d.dn_v = '0;
      s_d.act_v = 1'b0;
      for (int p = 0; p < NUM_PAIRS; p++) begin
         // regenerator forwards every downstream frame untouched
         if (IS_REGEN) begin
            s_d.dn_v[p] = i_dn_valid[p];
            if (i_dn_valid[p]) begin
               s_d.dn_f[p] = i_dn_frame[p];
            end
         end
         if (i_dn_valid[p]) begin
            fr = i_dn_frame[p];
            op = fr[INFO_HI:INFO_LO];
            // properly addressed opcode frame
            hit = (fr[ADDR_HI:ADDR_LO] == MY_ADDR) && fr[MSG_BIT];
            known = (op == OP_UNLATCH_ALL) || (op == OP_KEEP_LATCHED) ||
                    (op == OP_LOOPBACK) || (op == OP_CRC_REQUEST) ||
                    (op == OP_CRC_NOTIFY) || (op == OP_NEXT_BYTE);
            // next byte without a read in progress is out of state;
            // this block has no read mode, so it is always refused
            bad = !known || (op == OP_NEXT_BYTE);
            // network end judges global commands on one pair only
            sel_ok = IS_REGEN || (2'(p) == i_sel_pair);
            if (!hit) begin
               // not addressed: idle reply, regenerator stays transparent
               rsp = IDLE_FRAME;
               s_d.ovr[p] = 1'b0;
            end else begin
               // addressed regenerator takes over the upstream slot
               s_d.ovr[p] = 1'b1;
               if (run[p] == RUN_VALID && bad) begin
                  // third and later repeats of a refused command
                  rsp = CC_FRAME;
                  set_cc[p] = 1'b1;
               end else if (s_q.cc[p] && op != OP_UNLATCH_ALL) begin
                  // stuck until unlatch-all arrives three times
                  rsp = CC_FRAME;
               end else begin
                  // identical echo of the received frame
                  rsp = fr;
               end
               // act on the third identical frame, never earlier
               if (third[p] && !bad) begin
                  case (op)
                     OP_UNLATCH_ALL: begin
                        // clears all latches and cannot_comply
                        if (IS_REGEN) begin
                           clr[p] = 1'b1;
                        end else if (sel_ok) begin
                           clr = '1;
                        end
                     end
                     OP_LOOPBACK: begin
                        // global in the network end, per pair in regen
                        if (IS_REGEN) begin
                           set_loop[p] = 1'b1;
                        end else if (sel_ok) begin
                           set_loop = '1;
                        end
                     end
                     OP_CRC_REQUEST: begin
                        set_crq[p] = 1'b1;
                     end
                     OP_CRC_NOTIFY: begin
                        set_cnt[p] = 1'b1;
                     end
                     default: begin
                        // keep-latched idle: nothing changes
                     end
                  endcase
                  // pulse only where the command really took effect
                  if (op != OP_KEEP_LATCHED && (sel_ok || op == OP_CRC_REQUEST ||
                      op == OP_CRC_NOTIFY)) begin
                     s_d.act_v = 1'b1;
                     s_d.act_code = op;
                  end
               end
            end
            s_d.resp[p] = rsp;
            // network end answers in the very next returning frame,
            // on every pair that carried a frame, and only then
            if (!IS_REGEN) begin
               s_d.up_v[p] = 1'b1;
               s_d.up_f[p] = rsp;
            end
         end
         // regenerator upstream slot: pass through or overwrite
         if (IS_REGEN && i_up_valid[p]) begin
            s_d.up_v[p] = 1'b1;
            if (s_q.ovr[p]) begin
               s_d.up_f[p] = s_q.resp[p];
            end else begin
               s_d.up_f[p] = i_up_frame[p];
            end
         end
      end
      // set wins over clear in the same cycle
      s_d.loop = (s_q.loop & ~clr) | set_loop;
      s_d.crc_req = (s_q.crc_req & ~clr) | set_crq;
      s_d.crc_ntf = (s_q.crc_ntf & ~clr) | set_cnt;
      s_d.cc = (s_q.cc & ~clr) | set_cc;
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs, all straight from flip-flops
   // ************************************************************
   assign o_up_valid = s_q.up_v;
   assign o_up_frame = s_q.up_f;
   assign o_dn_valid = s_q.dn_v;
   assign o_dn_frame = s_q.dn_f;
   assign o_loopback = s_q.loop;
   assign o_crc_request = s_q.crc_req;
   assign o_crc_notify = s_q.crc_ntf;
   assign o_cannot_comply = s_q.cc;
   assign o_action = s_q.act_v;
   assign o_action_code = s_q.act_code;
endmodule
`default_nettype wire

// >>> design/oca_pkg.sv
package oca_pkg;
   // ************************************************************
   // frame layout, 13 bits, bit 12 is sent first
   // ************************************************************
   localparam int unsigned FRAME_W = 13;
   localparam int unsigned ADDR_HI = 12;   // address field, first bit
   localparam int unsigned ADDR_LO = 11;   // address field, second bit
   localparam int unsigned MSG_BIT = 10;   // one: opcode, zero: data
   localparam int unsigned ODD_BIT = 9;    // odd/even byte flag
   localparam int unsigned SPARE_BIT = 8;  // unused, always one
   localparam int unsigned INFO_HI = 7;    // information field, msb
   localparam int unsigned INFO_LO = 0;    // information field, lsb

   // ************************************************************
   // unit addresses
   // ************************************************************
   localparam logic [1:0] ADDR_MASTER = 2'h3;
   localparam logic [1:0] ADDR_NET_END = 2'h0;
   localparam logic [1:0] ADDR_REGEN = 2'h2;

   // ************************************************************
   // counting and reset values
   // ************************************************************
   localparam logic [1:0] RUN_VALID = 2'h3;  // identical receptions needed
   localparam logic [1:0] RUN_RST = 2'h0;
   localparam logic [12:0] FRAME_RST = 13'h0000;

   // ************************************************************
   // opcodes; cannot_comply is at least two bits away from all
   // other codes, keep_latched_idle included
   // ************************************************************
   localparam logic [7:0] OP_UNLATCH_ALL = 8'hFF;
   localparam logic [7:0] OP_KEEP_LATCHED = 8'h18;
   localparam logic [7:0] OP_CANNOT_COMPLY = 8'h0F;
   localparam logic [7:0] OP_LOOPBACK = 8'h50;
   localparam logic [7:0] OP_CRC_REQUEST = 8'h5A;
   localparam logic [7:0] OP_CRC_NOTIFY = 8'h5C;
   localparam logic [7:0] OP_NEXT_BYTE = 8'h30;
endpackage

// >>> design/oca_run_count.sv
`timescale 1ns/100ps
`default_nettype none
// counts identical consecutive frames on one pair
module oca_run_count
   import oca_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [12:0] i_frame,
   output logic [1:0] o_run,
   output logic o_third
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [12:0] last;  // previous frame on this pair
      logic [1:0] cnt;    // run length so far, saturates at three
   } oca_rc_t;

   oca_rc_t s_q;
   oca_rc_t s_d;

   // run including the frame now arriving
   always_comb begin
      s_d = s_q;
      o_run = s_q.cnt;
      o_third = 1'b0;
      if (i_valid) begin
         // any bit different restarts the run at one
         if (i_frame == s_q.last && s_q.cnt != RUN_RST) begin
            o_run = (s_q.cnt == RUN_VALID) ? RUN_VALID : s_q.cnt + 2'h1;
         end else begin
            o_run = 2'h1;
         end
         // third reception exactly, fires only once per run
         o_third = (o_run == RUN_VALID) && (s_q.cnt != RUN_VALID);
         s_d.last = i_frame;
         s_d.cnt = o_run;
      end
   end

   // registered copy
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '{last: FRAME_RST, cnt: RUN_RST};
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// >>> bench/oca_slave_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// port checker for the network-end slave, pair 0
// ************************************************************
module oca_slave_properties
   import oca_pkg::*;
#(
   parameter int unsigned NUM_PAIRS = 3,
   parameter bit IS_REGEN = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [NUM_PAIRS-1:0] i_dn_valid,
   input wire logic [NUM_PAIRS-1:0][12:0] i_dn_frame,
   input wire logic [NUM_PAIRS-1:0] o_up_valid,
   input wire logic [NUM_PAIRS-1:0][12:0] o_up_frame,
   input wire logic [NUM_PAIRS-1:0] o_loopback,
   input wire logic [NUM_PAIRS-1:0] o_cannot_comply,
   input wire logic o_action,
   input wire logic [7:0] o_action_code
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [NUM_PAIRS-1:0][12:0] last_q;  // previous frame per pair
   logic [NUM_PAIRS-1:0][1:0] run_q;    // identical run length, saturates at 3
   logic third_q;                       // some pair just reached its third copy
   // run counting is kept per pair, so counts never mix across pairs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_q <= '0;
         run_q <= '0;
         third_q <= 1'b0;
      end else begin
         third_q <= 1'b0;
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (i_dn_valid[p]) begin
               if (run_q[p] != 2'h0 && last_q[p] == i_dn_frame[p]) begin
                  if (run_q[p] == 2'h2) third_q <= 1'b1;
                  if (run_q[p] != 2'h3) run_q[p] <= run_q[p] + 2'h1;
               end else begin
                  run_q[p] <= 2'h1;  // any bit differing restarts the count
               end
               last_q[p] <= i_dn_frame[p];
            end
         end
      end
   end
   // addressed command frame on pair 0
   sequence s_addr;
      !IS_REGEN && i_dn_valid[0] && i_dn_frame[0][ADDR_HI:ADDR_LO] == ADDR_NET_END
         && i_dn_frame[0][MSG_BIT];
   endsequence
   sequence s_good;
      s_addr ##0 !o_cannot_comply[0] && i_dn_frame[0][INFO_HI:INFO_LO] == OP_LOOPBACK;
   endsequence
   echo_next_frame_a: assert property (!IS_REGEN && i_dn_valid[0] |=> o_up_valid[0])
      else $error("no reply in the frame after a command");
   no_unprompted_a: assert property (!IS_REGEN && !i_dn_valid[0] |=> !o_up_valid[0])
      else $error("reply sent without a command");
   echo_same_a: assert property (s_good |=> o_up_frame[0] == $past(i_dn_frame[0]))
      else $error("echo differs from the received frame");
   idle_reply_a: assert property (!IS_REGEN && i_dn_valid[0] &&
      (i_dn_frame[0][ADDR_HI:ADDR_LO] != ADDR_NET_END || !i_dn_frame[0][MSG_BIT])
      |=> o_up_frame[0] == {ADDR_NET_END, 3'b101, OP_KEEP_LATCHED})
      else $error("unaddressed frame not answered with keep-latched idle");
   action_third_a: assert property (o_action |-> third_q)
      else $error("action without three identical frames");
   loop_set_a: assert property ($rose(o_loopback[0]) |-> o_action && o_action_code == OP_LOOPBACK)
      else $error("loopback set without its command");
   loop_clear_a: assert property ($fell(o_loopback[0]) |-> o_action
      && o_action_code == OP_UNLATCH_ALL)
      else $error("loopback dropped without unlatch-all");
   cc_reply_a: assert property (s_addr ##0 o_cannot_comply[0]
      && i_dn_frame[0][INFO_HI:INFO_LO] != OP_UNLATCH_ALL
      |=> o_up_frame[0] == {ADDR_NET_END, 3'b101, OP_CANNOT_COMPLY})
      else $error("cannot-comply state did not answer cannot-comply");
   cc_exit_a: assert property ($fell(o_cannot_comply[0]) |-> o_action
      && o_action_code == OP_UNLATCH_ALL)
      else $error("cannot-comply left without unlatch-all");
endmodule
bind oca_slave oca_slave_properties #(.NUM_PAIRS(NUM_PAIRS), .IS_REGEN(IS_REGEN)) u_props (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dn_valid(i_dn_valid), .i_dn_frame(i_dn_frame),
   .o_up_valid(o_up_valid), .o_up_frame(o_up_frame), .o_loopback(o_loopback),
   .o_cannot_comply(o_cannot_comply), .o_action(o_action), .o_action_code(o_action_code));
`default_nettype wire

// >>> bench/oca_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// line_end_master model on one pair
// ************************************************************
module oca_master_model
   import oca_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_up_valid,
   input wire logic [12:0] i_up_frame,
   output logic o_dn_valid,
   output logic [12:0] o_dn_frame
);
   initial begin
      o_dn_valid = 1'b0;
      o_dn_frame = FRAME_RST;
   end
   // repeats one command until three identical echoes or cannot-comply replies; one command at a time
   task automatic send(input logic [12:0] f, input int gap, input int maxn, output bit done);
      logic [12:0] last;
      int run;
      done = 1'b0;
      run = 0;
      last = FRAME_RST;
      for (int n = 0; n < maxn && !done; n++) begin
         @(posedge i_clk);
         o_dn_valid <= 1'b1;
         o_dn_frame <= f;
         @(posedge i_clk);
         o_dn_valid <= 1'b0;
         o_dn_frame <= ~f;  // released lines must not look like the frame
         @(posedge i_clk);
         // identical replies counted on this pair only
         if (i_up_valid) begin
            run = (run != 0 && i_up_frame == last) ? run + 1 : 1;
            last = i_up_frame;
         end else begin
            run = 0;
         end
         // accepted on three echoes, abandoned on three cannot-comply replies
         if (run >= 3 && (last == f || last[7:0] == OP_CANNOT_COMPLY)) done = 1'b1;
         repeat (gap) @(posedge i_clk);  // slow master leaves gaps
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/tb_ops_channel_ack_protocol.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// testbench: network-end slave driven by a master model
// ************************************************************
module tb_ops_channel_ack_protocol;
   import oca_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:1] tb_v = '0;              // bench-driven pairs 1 and 2
   logic [12:0] tb_f1 = FRAME_RST;
   logic [1:0] sel = 2'h0;             // pair judged for global commands
   logic m_v;
   logic [12:0] m_f;
   logic [2:0] dn_v, up_v, loop, crq, cnt, ccs;
   logic [2:0][12:0] dn_f, up_f;
   logic act;
   logic [7:0] act_code;
   logic [12:0] exp_q[$];             // expected replies on pair 0
   logic [12:0] r_last = FRAME_RST;
   int r_run = 0;
   bit r_cc = 1'b0;
   int mismatches = 0;
   int compares = 0;
   bit done;
   logic [7:0] op;
   always #10 i_clk = ~i_clk;         // 50 MHz
   assign dn_v = {tb_v, m_v};
   assign dn_f = {~tb_f1, tb_f1, m_f};
   oca_master_model u_master (.i_clk(i_clk), .i_up_valid(up_v[0]), .i_up_frame(up_f[0]),
      .o_dn_valid(m_v), .o_dn_frame(m_f));
   oca_slave #(.NUM_PAIRS(3), .IS_REGEN(1'b0)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_dn_valid(dn_v), .i_dn_frame(dn_f), .i_up_valid(3'h0), .i_up_frame('0),
      .i_sel_pair(sel), .o_up_valid(up_v), .o_up_frame(up_f), .o_dn_valid(), .o_dn_frame(),
      .o_loopback(loop), .o_crc_request(crq), .o_crc_notify(cnt), .o_cannot_comply(ccs),
      .o_action(act), .o_action_code(act_code));
   function automatic logic [12:0] mk(input logic [1:0] a, input logic [7:0] c);
      return {a, 3'b101, c};
   endfunction
   task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ************************************************************
   // expected reply noted for every frame taken on pair 0
   // ************************************************************
   always @(posedge i_clk) begin
      if (i_rst_n && dn_v[0]) begin
         r_run = (r_run != 0 && dn_f[0] == r_last) ? ((r_run == 3) ? 3 : r_run + 1) : 1;
         r_last = dn_f[0];
         if (r_last[12:11] != ADDR_NET_END || !r_last[MSG_BIT]) begin
            exp_q.push_back(mk(ADDR_NET_END, OP_KEEP_LATCHED));
         end else if (r_cc && r_last[7:0] != OP_UNLATCH_ALL) begin
            exp_q.push_back(mk(ADDR_NET_END, OP_CANNOT_COMPLY));
         end else if (r_run == 3 && !(r_last[7:0] inside {OP_UNLATCH_ALL, OP_KEEP_LATCHED,
               OP_LOOPBACK, OP_CRC_REQUEST, OP_CRC_NOTIFY})) begin
            exp_q.push_back(mk(ADDR_NET_END, OP_CANNOT_COMPLY));
            r_cc = 1'b1;
         end else begin
            exp_q.push_back(r_last);
            if (r_run == 3 && r_last[7:0] == OP_UNLATCH_ALL) r_cc = 1'b0;
         end
      end
   end
   // reply monitor: the oldest note is compared with each reply seen
   always @(posedge i_clk) begin
      if (i_rst_n && up_v[0]) begin
         if (exp_q.size() == 0) check({12'h000, up_v[0]}, 13'h0000, "unexpected reply");
         else check(up_f[0], exp_q.pop_front(), "reply frame");
      end
   end
   // one command through the master; a missed bound closes the run
   task automatic cmd(input logic [12:0] f, input int gap, input int maxn, input bit expd);
      u_master.send(f, gap, maxn, done);
      check({12'h000, done}, {12'h000, expd}, "command done");
      if (expd && !done) give_verdict();
      repeat (2) @(posedge i_clk);
   endtask
   // three identical frames on pair 1, driven by the bench itself
   task automatic pair1(input logic [7:0] c);
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         tb_v[1] <= 1'b1;
         tb_f1 <= mk(ADDR_NET_END, c);
         @(posedge i_clk);
         tb_v[1] <= 1'b0;
         tb_f1 <= ~mk(ADDR_NET_END, c);
      end
      repeat (2) @(posedge i_clk);
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'h3766));
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      pair1(OP_LOOPBACK);  // loopback on a pair that is not selected
      check({10'h000, loop}, 13'h0000, "loopback off pair");
      check(up_f[1], mk(ADDR_NET_END, OP_LOOPBACK), "pair echo");
      cmd(mk(ADDR_NET_END, OP_LOOPBACK), 0, 12, 1'b1);
      check({10'h000, loop}, 13'h0007, "loopback global");
      check({5'h00, act_code}, {5'h00, OP_LOOPBACK}, "action code");
      cmd(mk(ADDR_NET_END, OP_CRC_REQUEST), 3, 12, 1'b1);
      check({10'h000, crq}, 13'h0001, "crc request pair");
      cmd(mk(ADDR_NET_END, OP_CRC_NOTIFY), 0, 12, 1'b1);
      check({10'h000, cnt}, 13'h0001, "crc notify pair");
      cmd(mk(ADDR_NET_END, OP_KEEP_LATCHED), 0, 12, 1'b1);
      check({10'h000, loop}, 13'h0007, "loopback held");
      cmd(mk(ADDR_REGEN, OP_LOOPBACK), 0, 2, 1'b0);
      op = 8'h60 + 8'($urandom_range(15, 0));
      cmd(mk(ADDR_NET_END, op), 1, 12, 1'b1);
      check({10'h000, ccs}, 13'h0001, "cannot comply set");
      cmd(mk(ADDR_NET_END, OP_UNLATCH_ALL), 0, 12, 1'b1);
      check({10'h000, ccs}, 13'h0000, "cannot comply left");
      check({4'h0, loop, crq, cnt}, 13'h0000, "latches cleared");
      cmd(mk(ADDR_NET_END, OP_NEXT_BYTE), 0, 12, 1'b1);
      check({10'h000, ccs}, 13'h0001, "next byte refused");
      cmd(mk(ADDR_NET_END, OP_UNLATCH_ALL), 2, 12, 1'b1);
      check({10'h000, ccs}, 13'h0000, "next byte state left");
      // global loopback judged on pair 1 once that pair is selected
      sel <= 2'h1;
      pair1(OP_KEEP_LATCHED);
      pair1(OP_LOOPBACK);
      check({10'h000, loop}, 13'h0007, "loopback selected pair");
      check({12'h000, $countones(OP_CANNOT_COMPLY ^ OP_LOOPBACK) >= 2 &&
         $countones(OP_CANNOT_COMPLY ^ OP_UNLATCH_ALL) >= 2 &&
         $countones(OP_CANNOT_COMPLY ^ OP_CRC_REQUEST) >= 2 &&
         $countones(OP_CANNOT_COMPLY ^ OP_CRC_NOTIFY) >= 2 &&
         $countones(OP_CANNOT_COMPLY ^ OP_NEXT_BYTE) >= 2}, 13'h0001, "code distance");
      give_verdict();
   end
endmodule
`default_nettype wire
